// ---- pkg/pacc_pkg.sv ----
// Register map, field layout and timing constants of the pulse accumulator
package pacc_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [15:0] IDX_ENABLES = 16'h1024;
  localparam logic [15:0] IDX_FLAGS = 16'h1025;
  localparam logic [15:0] IDX_CONTROL = 16'h1026;
  localparam logic [15:0] IDX_COUNT = 16'h1027;

  // Flag and enable bit positions (same position in both registers)
  localparam int BIT_COUNT_WRAP = 7;
  localparam int BIT_TICK = 6;
  localparam int BIT_ACC_WRAP = 5;
  localparam int BIT_ACC_EDGE = 4;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [3:0] ENABLES_RST = 4'h0;

  // Timing counts in bus-clock cycles
  localparam int TICK_BASE_LOG2 = 13;
  localparam int TICK_CNT_W = 16;
  localparam logic [5:0] GATE_DIV_LAST = 6'h3F;
  localparam logic [15:0] FRC_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] FRC_ZERO = 16'h0000;
  localparam logic [7:0] ACC_ALL_ONES = 8'hFF;

  // Accumulator control register fields, bit 7 down to bit 0
  typedef struct packed {
    logic unused7;
    logic accum_enable;
    logic accum_mode_sel;
    logic accum_edge_sel;
    logic unused3;
    logic capture_or_compare_sel;
    logic [1:0] periodic_rate_sel;
  } accum_control_t;

  localparam accum_control_t CONTROL_RST = '{default: 1'b0};

  // Register selected by a bus address
  typedef enum logic [4:0] {
    SEL_NONE = 5'b00001,
    SEL_ENABLES = 5'b00010,
    SEL_FLAGS = 5'b00100,
    SEL_CONTROL = 5'b01000,
    SEL_COUNT = 5'b10000
  } reg_sel_t;

endpackage

// ---- src/pulse_accumulator_rti_flags.sv ----
// Pulse accumulator, periodic tick and timer event flags behind AHB-Lite
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
// Behaviour
// - counter wrap flag on FFFF to 0000
// - flags clear only by writing one
// - tick flag set per period, bit6 clears
// - flag register bits 3:0 read zero
// - control bits 7 and 3 read zero
// - tick from clock/2^13, rate field divides further
// - tick period 2^13..2^16 cycles by rate
// - period counted from reset, not restarted by a timeout or rate write
// - 8-bit accumulator, mode event or gated
// - enable bit turns accumulator on or off
// - gated mode counts clock/64 while pin active
// - event mode edge select falling or rising
// - gated mode edge select picks inhibit level
// - select bit chooses compare five or capture four
// - count always read/write, unaffected by reset
// - increments never conflict with register reads
// - accumulator wrap flag on FF to 00, bit5 clears
// - wrap enable gates request, not the flag
// - edge flag on selected edge, bit4 clears
// - edge enable never touches edge flag
// - high enable bits pair with flag bits
module pulse_accumulator_rti_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Timer side
  input wire logic [15:0] free_running_count_i,
  input wire logic accum_input_pin_i,
  output logic capture_or_compare_sel_o,
  output logic timer_irq_o
);

  // Address decode shared by read and write paths
  function automatic pacc_pkg::reg_sel_t decode(input logic [31:0] a);
    decode = pacc_pkg::SEL_NONE;
    if (a[1:0] == 2'h0 && a[31:18] == 14'h0) begin
      if (a[17:2] == pacc_pkg::IDX_ENABLES) decode = pacc_pkg::SEL_ENABLES;
      if (a[17:2] == pacc_pkg::IDX_FLAGS) decode = pacc_pkg::SEL_FLAGS;
      if (a[17:2] == pacc_pkg::IDX_CONTROL) decode = pacc_pkg::SEL_CONTROL;
      if (a[17:2] == pacc_pkg::IDX_COUNT) decode = pacc_pkg::SEL_COUNT;
    end
  endfunction

  logic [7:0] flags_reg;
  logic [3:0] enables_reg;
  pacc_pkg::accum_control_t control_reg;
  logic [7:0] count_reg;
  logic wr_pend_reg;
  pacc_pkg::reg_sel_t wr_sel_reg;
  logic [15:0] frc_prev_reg;
  logic [pacc_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic [5:0] div64_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;

  // Bus request decode
  logic addr_phase;
  pacc_pkg::reg_sel_t addr_sel;
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign addr_sel = decode(haddr_i);

  // Write strobes seen in the data phase
  logic wr_flags, wr_enables, wr_control, wr_count;
  logic [7:0] wdata;
  assign wdata = hwdata_i[7:0];
  assign wr_flags = wr_pend_reg && wr_sel_reg == pacc_pkg::SEL_FLAGS;
  assign wr_enables = wr_pend_reg && wr_sel_reg == pacc_pkg::SEL_ENABLES;
  assign wr_control = wr_pend_reg && wr_sel_reg == pacc_pkg::SEL_CONTROL;
  assign wr_count = wr_pend_reg && wr_sel_reg == pacc_pkg::SEL_COUNT;

  // Zero wait states; response always OKAY
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Latch write address phase for the following data phase
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= pacc_pkg::SEL_NONE;
    end else begin
      wr_pend_reg <= addr_phase && hwrite_i;
      wr_sel_reg <= addr_sel;
    end
  end

  // Read data captured at the address phase edge, standing in data phase
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_phase && !hwrite_i) begin
      unique case (addr_sel)
        pacc_pkg::SEL_FLAGS: hrdata_o <= {24'h0, flags_reg[7:4], 4'h0};
        pacc_pkg::SEL_ENABLES: hrdata_o <= {24'h0, enables_reg, 4'h0};
        pacc_pkg::SEL_CONTROL: begin
          hrdata_o <= {24'h0, 1'b0, control_reg[6:4], 1'b0,
                       control_reg[2:0]};
        end
        pacc_pkg::SEL_COUNT: hrdata_o <= {24'h0, count_reg};
        pacc_pkg::SEL_NONE: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Two-flop synchroniser, then a stage for edge detection
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= accum_input_pin_i;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Edge and gate qualification from the synchronised pin
  logic rise, fall, sel_edge, gate_open, gate_close, div64_wrap;
  logic acc_inc, acc_wrap, acc_edge;
  assign rise = pin_sync_reg && !pin_prev_reg;
  assign fall = !pin_sync_reg && pin_prev_reg;
  assign sel_edge = control_reg.accum_edge_sel ? rise : fall;
  // Gate inhibits at the level named by edge select
  assign gate_open = pin_sync_reg ^ control_reg.accum_edge_sel;
  assign gate_close = control_reg.accum_edge_sel ? rise : fall;
  assign div64_wrap = div64_reg == pacc_pkg::GATE_DIV_LAST;
  always_comb begin
    acc_inc = 1'b0;
    acc_edge = 1'b0;
    if (control_reg.accum_enable) begin
      if (control_reg.accum_mode_sel) begin
        acc_inc = gate_open && div64_wrap;
        acc_edge = gate_close;
      end else begin
        acc_inc = sel_edge;
        acc_edge = sel_edge;
      end
    end
  end
  assign acc_wrap = acc_inc && !wr_count &&
                    count_reg == pacc_pkg::ACC_ALL_ONES;

  // Free-running divide by 64, never stopped except by reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div64_reg <= 6'h00;
    end else begin
      div64_reg <= div64_reg + 6'h01;
    end
  end

  // Count has no reset; a software write wins over an increment
  always_ff @(posedge clk_i) begin
    if (wr_count) begin
      count_reg <= wdata;
    end else if (acc_inc) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // Tick counter runs from reset, independent of any prescaler
  logic [15:0] tick_mask;
  logic tick;
  always_comb begin
    unique case (control_reg.periodic_rate_sel)
      2'h0: tick_mask = 16'h1FFF;
      2'h1: tick_mask = 16'h3FFF;
      2'h2: tick_mask = 16'h7FFF;
      2'h3: tick_mask = 16'hFFFF;
    endcase
  end
  assign tick = (tick_cnt_reg & tick_mask) == tick_mask;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // Free-running count wrap detection
  logic frc_wrap;
  assign frc_wrap = frc_prev_reg == pacc_pkg::FRC_ALL_ONES &&
                    free_running_count_i == pacc_pkg::FRC_ZERO;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      frc_prev_reg <= pacc_pkg::FRC_ZERO;
    end else begin
      frc_prev_reg <= free_running_count_i;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  logic [7:0] flag_set, flag_clr;
  assign flag_set = {frc_wrap, tick, acc_wrap, acc_edge, 4'h0};
  assign flag_clr = wr_flags ? wdata : 8'h00;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      flags_reg <= pacc_pkg::FLAGS_RST;
    end else begin
      flags_reg <= ((flags_reg & ~flag_clr) | flag_set) & 8'hF0;
    end
  end

  // Control and enables registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      control_reg <= pacc_pkg::CONTROL_RST;
      enables_reg <= pacc_pkg::ENABLES_RST;
    end else begin
      if (wr_control) begin
        control_reg <= pacc_pkg::accum_control_t'(wdata & 8'h77);
      end
      if (wr_enables) begin
        enables_reg <= wdata[7:4];
      end
    end
  end

  // Outputs straight from flops; enables gate only the request
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      timer_irq_o <= 1'b0;
      capture_or_compare_sel_o <= 1'b0;
    end else begin
      timer_irq_o <= |(flags_reg[7:4] & enables_reg);
      capture_or_compare_sel_o <= control_reg.capture_or_compare_sel;
    end
  end

  // Helper: cycles since last tick, valid if rate held since then
  logic [16:0] gap_reg;
  logic gap_ok_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gap_reg <= 17'h0_0001;
      gap_ok_reg <= 1'b1;
    end else if (tick) begin
      gap_reg <= 17'h0_0001;
      gap_ok_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 17'h0_0001;
      if (wr_control) gap_ok_reg <= 1'b0;
    end
  end

  // Helper: count holds a written value; it has no reset of its own
  logic count_known_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      count_known_reg <= 1'b0;
    end else if (wr_count) begin
      count_known_reg <= 1'b1;
    end
  end

  sequence s_flag_write(int b);
    wr_flags && wdata[b];
  endsequence

  sequence s_wrap_event;
    frc_prev_reg == 16'hFFFF ##0 free_running_count_i == 16'h0000;
  endsequence

  a_count_wrap_flag: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_wrap_event |=> flags_reg[7])
    else $error("count wrap flag not set after wrap");

  a_flag_sticky_hold: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    flags_reg[5] && !(wr_flags && wdata[5]) |=> flags_reg[5])
    else $error("accumulator wrap flag lost without clear");

  a_tick_flag_clear: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_flag_write(6) ##0 !tick |=> !flags_reg[6])
    else $error("tick flag survived a write of one");

  a_flag_low_zero: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    addr_phase && !hwrite_i && addr_sel == pacc_pkg::SEL_FLAGS
    |=> hrdata_o[3:0] == 4'h0 && hrdata_o[7:4] == $past(flags_reg[7:4]))
    else $error("flag register read wrong");

  a_control_reserved: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    addr_phase && !hwrite_i && addr_sel == pacc_pkg::SEL_CONTROL
    |=> !hrdata_o[7] && !hrdata_o[3])
    else $error("control reserved bits not zero");

  a_tick_spacing: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    tick && gap_ok_reg && !wr_control |-> gap_reg == {1'b0, tick_mask} + 17'h1)
    else $error("tick period wrong");

  a_gated_step: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    control_reg.accum_enable && control_reg.accum_mode_sel && gate_open &&
    div64_wrap && !wr_count && count_known_reg
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("gated count did not step");

  a_disabled_hold: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    count_known_reg && !control_reg.accum_enable && !wr_count
    |=> $stable(count_reg))
    else $error("count moved while disabled");

  a_edge_flag_set: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    control_reg.accum_enable && !control_reg.accum_mode_sel && sel_edge
    |=> flags_reg[4])
    else $error("edge flag not set on selected edge");

  a_acc_wrap_flag: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    acc_inc && !wr_count && count_reg == 8'hFF
    |=> count_reg == 8'h00 && flags_reg[5])
    else $error("accumulator wrap not flagged");

  a_irq_follows: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ##1 timer_irq_o == |($past(flags_reg[7:4]) & $past(enables_reg)))
    else $error("interrupt request mismatch");

endmodule

// ---- dv/pulse_source.sv ----
// Pulse source model driving the accumulator input pin
`timescale 1ns/100ps
module pulse_source (
  // Clock
  input wire logic clk_i,
  // Request from the bench
  input wire logic start_i,
  input wire logic [7:0] count_i,
  input wire logic [15:0] high_len_i,
  // Pin side
  output logic busy_o,
  output logic pin_o
);
  logic [7:0] left_reg = 8'h00;
  logic [15:0] tmr_reg = 16'h0000;
  logic pin_reg = 1'b0;

  // Pulse train; low time never under 3 cycles, high time one cycle longer than asked
  always @(posedge clk_i) begin
    if (start_i) begin
      left_reg <= count_i;
      tmr_reg <= 16'h0003;
    end else if (tmr_reg != 16'h0000) begin
      tmr_reg <= tmr_reg - 16'h0001;
    end else if (pin_reg) begin
      pin_reg <= 1'b0;
      tmr_reg <= 16'h0003;
      left_reg <= left_reg - 8'h01;
    end else if (left_reg != 8'h00) begin
      pin_reg <= 1'b1;
      tmr_reg <= high_len_i;
    end
  end

  assign pin_o = pin_reg;
  assign busy_o = (left_reg != 8'h00) || (tmr_reg != 16'h0000);
endmodule

// ---- dv/pulse_accumulator_rti_flags_tb.sv ----
// Self-checking bench for the accumulator, tick and event flags
`timescale 1ns/100ps
module pulse_accumulator_rti_flags_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [15:0] frc = 16'hFFF0;
  logic frc_run = 1'b0;
  logic pin;
  logic ps_start = 1'b0;
  logic [7:0] ps_count = 8'h00;
  logic [15:0] ps_high = 16'h0003;
  logic ps_busy;
  logic sel;
  logic irq;
  logic rd_phase = 1'b0;
  logic [7:0] q_exp[$];
  logic [7:0] cfg [3] = '{8'h50, 8'h40, 8'h10};
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0;
  int t1;
  int c;
  int n;
  logic en;

  // Clock, 20 ns period
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  pulse_accumulator_rti_flags DUT (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp),
    .free_running_count_i(frc), .accum_input_pin_i(pin),
    .capture_or_compare_sel_o(sel), .timer_irq_o(irq)
  );

  pulse_source src (
    .clk_i(clk_i), .start_i(ps_start), .count_i(ps_count),
    .high_len_i(ps_high), .busy_o(ps_busy), .pin_o(pin)
  );

  // Cycle count and external timer count stimulus
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (frc_run) begin
      frc <= frc + 16'h0001;
    end
  end

  // Read data checked against the oldest note at the data-phase edge
  always @(posedge clk_i) begin
    if (rd_phase) begin
      check_val(hrdata, {24'h0, q_exp.pop_front()});
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait; a stuck signal ends the run as a failure
  task automatic hold(input int lim, ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v) begin
      k++;
      if (k > lim) begin
        n_errors++;
        give_verdict();
      end
      @(posedge clk_i);
    end
  endtask

  // One AHB single transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [7:0] d, input logic [7:0] e);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_i);
    hold(16, hready, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    if (!w) begin
      q_exp.push_back(e);
      rd_phase <= 1'b1;
    end
    @(posedge clk_i);
    hold(16, hready, 1'b1);
    rd_phase <= 1'b0;
  endtask

  task automatic send(input int k, input logic [15:0] h);
    @(posedge clk_i);
    ps_start <= 1'b1;
    ps_count <= 8'(k);
    ps_high <= h;
    @(posedge clk_i);
    ps_start <= 1'b0;
    repeat (2) @(posedge clk_i);
    hold(4000, ps_busy, 1'b0);
    repeat (6) @(posedge clk_i);
  endtask

  // Cycle stamp of the next tick request
  task automatic tick_at(output int t);
    xfer(1'b1, pacc_pkg::IDX_FLAGS, 8'h40, 8'h00);
    repeat (2) @(posedge clk_i);
    hold(70000, irq, 1'b1);
    t = cyc;
  endtask

  initial begin
    void'($urandom(59));
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    xfer(1'b0, pacc_pkg::IDX_FLAGS, 8'h00, 8'h00);
    xfer(1'b0, pacc_pkg::IDX_ENABLES, 8'h00, 8'h00);
    xfer(1'b1, 16'h1028, 8'hFF, 8'h00);
    xfer(1'b0, 16'h1028, 8'h00, 8'h00);
    xfer(1'b1, pacc_pkg::IDX_CONTROL, 8'hFF, 8'h00);
    xfer(1'b0, pacc_pkg::IDX_CONTROL, 8'h00, 8'h77);
    check_val({31'h0, sel}, 32'h1);
    xfer(1'b1, pacc_pkg::IDX_ENABLES, 8'h10, 8'h00);
    // Event counting: rising, falling, then disabled
    for (int i = 0; i < 3; i++) begin
      c = 252 + $urandom_range(0, 3);
      n = $urandom_range(1, 4);
      en = cfg[i][6];
      xfer(1'b1, pacc_pkg::IDX_CONTROL, cfg[i], 8'h00);
      xfer(1'b1, pacc_pkg::IDX_COUNT, 8'(c), 8'h00);
      send(n, 16'h0003 + 16'($urandom_range(0, 3)));
      xfer(1'b0, pacc_pkg::IDX_COUNT, 8'h00, 8'(en ? c + n : c));
      xfer(1'b1, pacc_pkg::IDX_FLAGS, 8'h0F, 8'h00);
      xfer(1'b0, pacc_pkg::IDX_FLAGS, 8'h00,
           {2'b00, en && (c + n > 255), en, 4'h0});
      check_val({31'h0, irq}, {31'h0, en});
      xfer(1'b1, pacc_pkg::IDX_FLAGS, 8'h30, 8'h00);
      xfer(1'b0, pacc_pkg::IDX_FLAGS, 8'h00, 8'h00);
      check_val({31'h0, irq}, 32'h0);
    end
    check_val({31'h0, sel}, 32'h0);
    // Gated: 256 open cycles give four divide-by-64 steps
    // High length 255 keeps the pin high exactly 256 cycles, any phase
    xfer(1'b1, pacc_pkg::IDX_CONTROL, 8'h60, 8'h00);
    xfer(1'b1, pacc_pkg::IDX_COUNT, 8'h00, 8'h00);
    send(1, 16'h00FF);
    xfer(1'b0, pacc_pkg::IDX_COUNT, 8'h00, 8'h04);
    xfer(1'b0, pacc_pkg::IDX_FLAGS, 8'h00, 8'h10);
    xfer(1'b1, pacc_pkg::IDX_FLAGS, 8'h30, 8'h00);
    // Free-running count crosses FFFF to 0000
    frc_run <= 1'b1;
    repeat (24) @(posedge clk_i);
    frc_run <= 1'b0;
    xfer(1'b0, pacc_pkg::IDX_FLAGS, 8'h00, 8'h80);
    xfer(1'b1, pacc_pkg::IDX_ENABLES, 8'h80, 8'h00);
    xfer(1'b0, pacc_pkg::IDX_ENABLES, 8'h00, 8'h80);
    check_val({31'h0, irq}, 32'h1);
    xfer(1'b1, pacc_pkg::IDX_FLAGS, 8'h80, 8'h00);
    // Tick periods at rate 0 and rate 1
    xfer(1'b1, pacc_pkg::IDX_ENABLES, 8'h40, 8'h00);
    tick_at(t0);
    check_val(32'(t0 >= 8192 && t0 <= 8200), 32'h1);
    tick_at(t1);
    check_val(32'(t1 - t0), 32'h0000_2000);
    xfer(1'b1, pacc_pkg::IDX_CONTROL, 8'h01, 8'h00);
    tick_at(t0);
    tick_at(t1);
    check_val(32'(t1 - t0), 32'h0000_4000);
    give_verdict();
  end
endmodule
